/* core/gas_params.svh */
// Constants of the generator alarm supervisor: offsets, reset values, timing.
// Assumes a 250 MHz clock; measurements arrive already scaled to the units below.
`ifndef GAS_PARAMS_SVH
`define GAS_PARAMS_SVH

`define GAS_ACT_DISABLED 3'h1
`define GAS_ACT_WARNING  3'h2
`define GAS_ACT_AUDIBLE  3'h4
`define GAS_ACT_SOFT     3'h5
`define GAS_ACT_HARD     3'h6

`define GAS_OFF_CTRL     12'h000
`define GAS_OFF_ACT0     12'h004
`define GAS_OFF_ACT1     12'h008
`define GAS_OFF_SUPPLY   12'h00C
`define GAS_OFF_GENV_HI  12'h010
`define GAS_OFF_GENV_LO  12'h014
`define GAS_OFF_NSEQ     12'h018
`define GAS_OFF_DELAYS   12'h01C
`define GAS_OFF_STATUS   12'h020
`define GAS_OFF_EVENT    12'h024

`define GAS_RST_CTRL     32'h00000000
`define GAS_RST_ACT0     24'hDA25A4
`define GAS_RST_ACT1     9'h149
`define GAS_RST_SUPPLY   32'h00B40118
`define GAS_RST_GENV_HI  32'h02260258
`define GAS_RST_GENV_LO  32'h0190012C
`define GAS_RST_NSEQ     7'h32
`define GAS_RST_DELAYS   32'h00320064

`define GAS_TICK_MS      100
`define GAS_CLK_KHZ      250000
`define GAS_SUPPLY_TICKS 11'h00A
`define GAS_ARM_TICKS    11'h032
`define GAS_TRIM_TICKS   11'h064
`define GAS_FREQ_ERR     16'h0064

`endif

/* core/gas_pkg.sv */
// Types of the generator alarm supervisor.
// Assumes gas_params.svh supplies all numeric constants.
package gas_pkg;
    typedef logic [2:0] gas_action_t;
    typedef struct packed {
        logic [15:0] supply_dv;
        logic [15:0] gen_freq_chz;
        logic [15:0] speed_freq_chz;
        logic [6:0]  neg_seq_pct;
        logic [15:0] phase_a_v;
        logic [15:0] phase_b_v;
        logic [15:0] phase_c_v;
    } gas_meas_t;
    typedef struct packed {
        logic starter_on;
        logic at_rated_speed;
        logic sync_enabled;
        logic breaker_closed;
        logic speed_bias_at_limit;
        logic volt_bias_at_max_v;
        logic volt_bias_at_min_v;
        logic volt_bias_at_var;
        logic measure_board_fault;
    } gas_stat_t;
endpackage

/* core/gas_alarm_supervisor.sv */
// Alarm supervisor: level compare, enables, qualification timers, APB registers.
// Assumes measurements and status are synchronous to clock and already scaled.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "gas_params.svh"
module gas_alarm_supervisor #(
    parameter int unsigned TICK_CYCLES = `GAS_TICK_MS * `GAS_CLK_KHZ
) (
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire logic                 ce,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire gas_pkg::gas_meas_t   meas,
    input  wire gas_pkg::gas_stat_t   stat,
    output logic      [10:0]          trip,
    output logic      [10:0]          event_pulse,
    output gas_pkg::gas_action_t [10:0] alarm_action
);
    localparam int N = 11;

    logic [31:0]          ctrl_q;
    logic [32:0]          act_q;
    logic [31:0]          supply_q;
    logic [31:0]          genv_hi_q;
    logic [31:0]          genv_lo_q;
    logic [6:0]           nseq_q;
    logic [31:0]          delays_q;
    logic [10:0]          event_sticky_q;
    logic [31:0]          prdata_q;
    logic                 pready_q;
    logic                 pslverr_q;
    logic [24:0]          tick_cnt_q;
    logic                 tick_q;
    logic [10:0]          arm_cnt_q;
    logic [10:0]          trip_q;
    logic [10:0]          event_q;
    gas_pkg::gas_action_t [10:0] action_q;
    logic [10:0]          cnt_q [N];
    logic [10:0]          cond;
    logic [10:0]          dly [N];
    logic [10:0]          hit;
    logic [15:0]          v_max;
    logic [15:0]          v_min;
    logic [15:0]          v_low;
    logic [15:0]          freq_err;
    logic                 armed;
    logic                 wr_en;
    logic                 rd_en;

    // APB: one wait state, answer registered
    assign wr_en = ce && psel && penable && pready_q && pwrite;
    assign rd_en = ce && psel && penable && !pready_q;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else if (ce)
        begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= 1'b0;
            if (rd_en)
            begin
                prdata_q <= 32'h00000000;
                if (paddr == `GAS_OFF_CTRL)
                    prdata_q <= ctrl_q;
                else if (paddr == `GAS_OFF_ACT0)
                    prdata_q <= {8'h00, act_q[23:0]};
                else if (paddr == `GAS_OFF_ACT1)
                    prdata_q <= {23'h000000, act_q[32:24]};
                else if (paddr == `GAS_OFF_SUPPLY)
                    prdata_q <= supply_q;
                else if (paddr == `GAS_OFF_GENV_HI)
                    prdata_q <= genv_hi_q;
                else if (paddr == `GAS_OFF_GENV_LO)
                    prdata_q <= genv_lo_q;
                else if (paddr == `GAS_OFF_NSEQ)
                    prdata_q <= {25'h0000000, nseq_q};
                else if (paddr == `GAS_OFF_DELAYS)
                    prdata_q <= delays_q;
                else if (paddr == `GAS_OFF_STATUS)
                    prdata_q <= {21'h000000, trip_q};
                else if (paddr == `GAS_OFF_EVENT)
                    prdata_q <= {21'h000000, event_sticky_q};
                else
                    pslverr_q <= 1'b1;
            end
        end
    end

    // Configuration; implemented bits are stored as written, range limits are software's job
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q    <= `GAS_RST_CTRL;
            act_q     <= {`GAS_RST_ACT1, `GAS_RST_ACT0};
            supply_q  <= `GAS_RST_SUPPLY;
            genv_hi_q <= `GAS_RST_GENV_HI;
            genv_lo_q <= `GAS_RST_GENV_LO;
            nseq_q    <= `GAS_RST_NSEQ;
            delays_q  <= `GAS_RST_DELAYS;
        end
        else if (wr_en)
        begin
            if (paddr == `GAS_OFF_CTRL)
                ctrl_q <= {31'h00000000, pwdata[0]};
            else if (paddr == `GAS_OFF_ACT0)
                act_q[23:0] <= pwdata[23:0];
            else if (paddr == `GAS_OFF_ACT1)
                act_q[32:24] <= pwdata[8:0];
            else if (paddr == `GAS_OFF_SUPPLY)
                supply_q <= pwdata;
            else if (paddr == `GAS_OFF_GENV_HI)
                genv_hi_q <= pwdata;
            else if (paddr == `GAS_OFF_GENV_LO)
                genv_lo_q <= pwdata;
            else if (paddr == `GAS_OFF_NSEQ)
                nseq_q <= pwdata[6:0];
            else if (paddr == `GAS_OFF_DELAYS)
                delays_q <= {5'h00, pwdata[26:16], 5'h00, pwdata[10:0]};
        end
    end

    // 0.1 s time base; shared, so each delay is exact to within one tick
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_cnt_q <= 25'h0000000;
            tick_q     <= 1'b0;
        end
        else if (ce)
        begin
            tick_q <= (tick_cnt_q == 25'(TICK_CYCLES - 1));
            if (tick_cnt_q == 25'(TICK_CYCLES - 1))
                tick_cnt_q <= 25'h0000000;
            else
                tick_cnt_q <= tick_cnt_q + 25'h0000001;
        end
    end

    // Rated-speed arming timer
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            arm_cnt_q <= 11'h000;
        else if (ce)
        begin
            if (!stat.at_rated_speed)
                arm_cnt_q <= 11'h000;
            else if (tick_q && arm_cnt_q < `GAS_ARM_TICKS)
                arm_cnt_q <= arm_cnt_q + 11'h001;
        end
    end
    assign armed = (arm_cnt_q >= `GAS_ARM_TICKS);

    // Voltage selection and frequency error
    always_comb
    begin
        v_max = meas.phase_a_v;
        v_min = meas.phase_a_v;
        if (meas.phase_b_v > v_max)
            v_max = meas.phase_b_v;
        if (meas.phase_c_v > v_max)
            v_max = meas.phase_c_v;
        if (meas.phase_b_v < v_min)
            v_min = meas.phase_b_v;
        if (meas.phase_c_v < v_min)
            v_min = meas.phase_c_v;
        v_low = ctrl_q[0] ? meas.phase_a_v : v_min;
        if (meas.gen_freq_chz > meas.speed_freq_chz)
            freq_err = meas.gen_freq_chz - meas.speed_freq_chz;
        else
            freq_err = meas.speed_freq_chz - meas.gen_freq_chz;
    end

    // Enabled violation per alarm
    always_comb
    begin
        cond[0]  = !stat.starter_on && meas.supply_dv > supply_q[15:0];
        cond[1]  = !stat.starter_on && meas.supply_dv < supply_q[31:16];
        cond[2]  = armed && freq_err > `GAS_FREQ_ERR;
        cond[3]  = stat.speed_bias_at_limit;
        cond[4]  = stat.volt_bias_at_max_v || stat.volt_bias_at_min_v || stat.volt_bias_at_var;
        cond[5]  = stat.measure_board_fault;
        cond[6]  = stat.sync_enabled && meas.neg_seq_pct > nseq_q;
        cond[7]  = v_max > genv_hi_q[15:0];
        cond[8]  = v_max > genv_hi_q[31:16];
        cond[9]  = stat.breaker_closed && v_low < genv_lo_q[31:16];
        cond[10] = stat.breaker_closed && v_low < genv_lo_q[15:0];
        dly[0]   = `GAS_SUPPLY_TICKS;
        dly[1]   = `GAS_SUPPLY_TICKS;
        dly[2]   = 11'h000;
        dly[3]   = `GAS_TRIM_TICKS;
        dly[4]   = `GAS_TRIM_TICKS;
        dly[5]   = 11'h000;
        dly[6]   = 11'h000;
        dly[7]   = delays_q[10:0];
        dly[8]   = delays_q[26:16];
        dly[9]   = delays_q[26:16];
        dly[10]  = delays_q[10:0];
    end

    // Qualification timers and trip outputs
    for (genvar i = 0; i < N; i++)
    begin : g_alarm
        assign hit[i] = cond[i] && cnt_q[i] >= dly[i];
        always_ff @(posedge clock or negedge nrst)
        begin
            if (!nrst)
                cnt_q[i] <= 11'h000;
            else if (ce)
            begin
                if (!cond[i])
                    cnt_q[i] <= 11'h000;
                else if (tick_q && cnt_q[i] < dly[i])
                    cnt_q[i] <= cnt_q[i] + 11'h001;
            end
        end
        always_ff @(posedge clock or negedge nrst)
        begin
            if (!nrst)
            begin
                trip_q[i]   <= 1'b0;
                event_q[i]  <= 1'b0;
                action_q[i] <= 3'h0;
            end
            else if (ce)
            begin
                trip_q[i]   <= hit[i] && act_q[3*i +: 3] != `GAS_ACT_DISABLED;
                event_q[i]  <= hit[i] && act_q[3*i +: 3] != `GAS_ACT_DISABLED && !trip_q[i];
                action_q[i] <= (hit[i] && act_q[3*i +: 3] != `GAS_ACT_DISABLED) ? act_q[3*i +: 3] : 3'h0;
            end
        end
    end

    // Sticky event flags, write one to clear; a new event beats the clear
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            event_sticky_q <= 11'h000;
        else if (ce)
        begin
            if (wr_en && paddr == `GAS_OFF_EVENT)
                event_sticky_q <= (event_sticky_q & ~pwdata[10:0]) | event_q;
            else
                event_sticky_q <= event_sticky_q | event_q;
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign trip         = trip_q;
    assign event_pulse  = event_q;
    assign alarm_action = action_q;

    property p_starter_blocks;
        @(posedge clock) disable iff (!nrst)
        ce && stat.starter_on |=> !trip_q[0] && !trip_q[1];
    endproperty
    a_starter_blocks: assert property (p_starter_blocks) else $error("supply alarm during crank");

    property p_arm_drop;
        @(posedge clock) disable iff (!nrst)
        ce && !stat.at_rated_speed |=> !armed ##1 (!ce || !trip_q[2]) || stat.at_rated_speed;
    endproperty
    a_arm_drop: assert property (p_arm_drop) else $error("mismatch trip while not armed");

    property p_sync_gate;
        @(posedge clock) disable iff (!nrst)
        ce && !stat.sync_enabled |=> !trip_q[6];
    endproperty
    a_sync_gate: assert property (p_sync_gate) else $error("rotation trip without synchronizer");

    property p_breaker_gate;
        @(posedge clock) disable iff (!nrst)
        ce && !stat.breaker_closed |=> !trip_q[9] && !trip_q[10];
    endproperty
    a_breaker_gate: assert property (p_breaker_gate) else $error("undervoltage trip with breaker open");

    property p_board_fault;
        @(posedge clock) disable iff (!nrst)
        ce && stat.measure_board_fault && act_q[17:15] != `GAS_ACT_DISABLED |=> trip_q[5];
    endproperty
    a_board_fault: assert property (p_board_fault) else $error("board fault not tripped");

    property p_restart;
        @(posedge clock) disable iff (!nrst)
        ce && !cond[7] |=> cnt_q[7] == 11'h000;
    endproperty
    a_restart: assert property (p_restart) else $error("timer not restarted");

    property p_ov_qualified;
        @(posedge clock) disable iff (!nrst)
        $rose(trip_q[7]) |-> $past(cnt_q[7]) >= $past(delays_q[10:0]);
    endproperty
    a_ov_qualified: assert property (p_ov_qualified) else $error("overvoltage trip before delay");

    property p_action_shown;
        @(posedge clock) disable iff (!nrst)
        trip_q[7] |-> alarm_action[7] == $past(act_q[23:21]) && alarm_action[7] != `GAS_ACT_DISABLED;
    endproperty
    a_action_shown: assert property (p_action_shown) else $error("wrong action code on trip");

    property p_event_rise;
        @(posedge clock) disable iff (!nrst)
        $rose(trip_q[7]) |-> event_q[7] ##1 (!ce || !event_q[7]);
    endproperty
    a_event_rise: assert property (p_event_rise) else $error("event flag not one pulse");

    property p_sticky_set;
        @(posedge clock) disable iff (!nrst)
        ce && event_q[5] |=> event_sticky_q[5];
    endproperty
    a_sticky_set: assert property (p_sticky_set) else $error("event not latched");

    property p_disabled_quiet;
        @(posedge clock) disable iff (!nrst)
        ce && act_q[17:15] == `GAS_ACT_DISABLED |=> !trip_q[5] && !event_q[5] && alarm_action[5] == 3'h0;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled alarm tripped");

    property p_trim_qualified;
        @(posedge clock) disable iff (!nrst)
        $rose(trip_q[3]) |-> $past(cnt_q[3]) >= `GAS_TRIM_TICKS;
    endproperty
    a_trim_qualified: assert property (p_trim_qualified) else $error("speed trim trip before delay");

    c_supply_trip: cover property (@(posedge clock) disable iff (!nrst) $rose(trip_q[0]));
    c_mismatch_trip: cover property (@(posedge clock) disable iff (!nrst) $rose(trip_q[2]));
    c_uv_trip: cover property (@(posedge clock) disable iff (!nrst) $rose(trip_q[10]));
    c_trim_trip: cover property (@(posedge clock) disable iff (!nrst) $rose(trip_q[3]));
    c_event_clear: cover property (@(posedge clock) disable iff (!nrst)
        wr_en && paddr == `GAS_OFF_EVENT && |event_sticky_q);
endmodule

/* test/gas_front_model.sv */
// Model of the measurement front ends and controller status flags.
// Assumes the bench names the wanted values; outputs move on the clock edge.
`timescale 1ns/1ps
module gas_front_model (
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire gas_pkg::gas_meas_t meas_want,
    input  wire gas_pkg::gas_stat_t stat_want,
    output gas_pkg::gas_meas_t      meas,
    output gas_pkg::gas_stat_t      stat
);
    // Front ends refresh once a clock; flags read inactive in reset
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            meas <= '0;
            stat <= '0;
        end
        else
        begin
            meas <= meas_want;
            stat <= stat_want;
        end
    end
endmodule

/* test/gas_alarm_supervisor_tb.sv */
// Self-checking bench for the generator alarm supervisor.
// Assumes a short time base (TICK_CYCLES 10); clock enable high except one freeze.
`timescale 1ns/1ps
`include "gas_params.svh"
module gas_alarm_supervisor_tb;
    localparam int T = 10;
    logic                        clock = 1'b0;
    logic                        ce = 1'b1;
    logic                        nrst = 1'b0;
    logic                        psel = 1'b0;
    logic                        penable = 1'b0;
    logic                        pwrite = 1'b0;
    logic [11:0]                 paddr = 12'h000;
    logic [31:0]                 pwdata = 32'h00000000;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    gas_pkg::gas_meas_t          mw;
    gas_pkg::gas_meas_t          nom;
    gas_pkg::gas_meas_t          meas;
    gas_pkg::gas_stat_t          sw;
    gas_pkg::gas_stat_t          stat;
    logic [10:0]                 trip;
    logic [10:0]                 event_pulse;
    gas_pkg::gas_action_t [10:0] alarm_action;
    logic [2:0]                  act [11];
    logic [31:0]                 rv [8];
    logic [31:0]                 q;
    logic                        e;
    logic [6:0]                  pct;
    logic                        sy;
    int                          fails = 0;
    int                          comparisons = 0;
    int                          seed = 32'hf86f673a;

    always #2 clock = ~clock;

    gas_front_model i_front (.clock(clock), .nrst(nrst), .meas_want(mw), .stat_want(sw), .meas(meas), .stat(stat));
    gas_alarm_supervisor #(.TICK_CYCLES(T)) i_dut (.clock(clock), .nrst(nrst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .meas(meas), .stat(stat), .trip(trip), .event_pulse(event_pulse),
        .alarm_action(alarm_action));

    function automatic logic [2:0] exp_act(input int i);
        return act[i];
    endfunction

    function automatic logic exp_nseq(input logic [6:0] p, input logic s);
        return s && (p > `GAS_RST_NSEQ);
    endfunction

    task automatic stop_test();
        if (fails == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && k < 20)
        begin
            @(posedge clock);
            k++;
        end
        if (k == 20)
        begin
            chk(0, 1);
            stop_test();
        end
        // Answer taken at the edge that sees pready, then released
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_act(input int i, input logic [2:0] c);
        logic [32:0] p;
        act[i] = c;
        for (int j = 0; j < 11; j++)
            p[3*j +: 3] = act[j];
        apb(1'b1, `GAS_OFF_ACT1, {23'h000000, p[32:24]});
        apb(1'b1, `GAS_OFF_ACT0, {8'h00, p[23:0]});
        // New code reaches the outputs one edge after it lands
        repeat (2) @(negedge clock);
    endtask

    // Trip must stay low for lo cycles and rise before hi
    task automatic wt(input int i, input int lo, input int hi);
        int k;
        k = 0;
        while (trip[i] !== 1'b1 && k < hi)
        begin
            @(negedge clock);
            k++;
        end
        chk({trip[i], 31'(k >= lo)}, {1'b1, 31'h1});
        chk(32'(alarm_action[i]), 32'(exp_act(i)));
        if (trip[i] !== 1'b1)
            stop_test();
    endtask

    // Settle, then trip and code must stay zero
    task automatic quiet(input int i, input int cyc);
        int h;
        h = 0;
        repeat (3) @(negedge clock);
        repeat (cyc)
        begin
            @(negedge clock);
            if (trip[i] !== 1'b0 || alarm_action[i] !== 3'h0)
                h++;
        end
        chk(h, 0);
    endtask

    initial
    begin
        act = '{3'h4, 3'h4, 3'h6, 3'h2, 3'h2, 3'h4, 3'h6, 3'h6, 3'h1, 3'h1, 3'h5};
        rv = '{32'h0, 32'hDA25A4, 32'h149, 32'h00B40118, 32'h02260258, 32'h0190012C, 32'h32, 32'h00320064};
        nom = '{16'h00F0, 16'h1770, 16'h1770, 7'h00, 16'h01E0, 16'h01E0, 16'h01E0};
        mw = nom;
        sw = '0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        for (int j = 0; j < 8; j++)
        begin
            apb(1'b0, 12'(4 * j), 32'h0);
            chk(q, rv[j]);
        end
        apb(1'b0, 12'h100, 32'h0);
        chk(q, 32'h0);
        chk(32'(e), 32'h1);
        apb(1'b1, `GAS_OFF_DELAYS, 32'h00020003);
        // Board fault: off code blocks it, then codes pass through
        set_act(5, 3'h1);
        sw.measure_board_fault <= 1'b1;
        quiet(5, 10);
        set_act(5, 3'h4);
        wt(5, 0, 6);
        chk(32'(event_pulse[5]), 32'h1);
        @(negedge clock);
        chk(32'(event_pulse[5]), 32'h0);
        apb(1'b0, `GAS_OFF_STATUS, 32'h0);
        chk(q, 32'h20);
        apb(1'b0, `GAS_OFF_EVENT, 32'h0);
        chk(32'(q[5]), 32'h1);
        apb(1'b1, `GAS_OFF_EVENT, 32'h20);
        apb(1'b0, `GAS_OFF_EVENT, 32'h0);
        chk(32'(q[5]), 32'h0);
        foreach (rv[j])
        begin
            set_act(5, (j < 4) ? 3'(j + 2 + (j > 1)) : 3'h4);
            wt(5, 0, 3);
        end
        @(posedge clock);
        sw.measure_board_fault <= 1'b0;
        quiet(5, 5);
        // Negative sequence, corners then random
        for (int j = 0; j < 24; j++)
        begin
            pct = (j < 4) ? 7'(50 + (j % 2) + 49 * (j / 2) * (j % 2)) : 7'({$random(seed)} % 101);
            sy = (j < 3) ? 1'b1 : (j == 3) ? 1'b0 : 1'($random(seed));
            @(posedge clock);
            mw.neg_seq_pct <= pct;
            sw.sync_enabled <= sy;
            repeat (3) @(negedge clock);
            chk(32'(trip[6]), 32'(exp_nseq(pct, sy)));
        end
        @(posedge clock);
        sw.sync_enabled <= 1'b0;
        sw.starter_on <= 1'b1;
        mw.supply_dv <= 16'h0119;
        quiet(0, 150);
        @(posedge clock);
        sw.starter_on <= 1'b0;
        wt(0, 9 * T, 11 * T + 6);
        @(posedge clock);
        mw.supply_dv <= 16'h0118;
        quiet(0, 130);
        @(posedge clock);
        mw.supply_dv <= 16'h00B3;
        repeat (60) @(negedge clock);
        @(posedge clock);
        mw.supply_dv <= 16'h00F0;
        @(posedge clock);
        mw.supply_dv <= 16'h00B3;
        wt(1, 9 * T, 11 * T + 6);
        @(posedge clock);
        mw <= nom;
        mw.gen_freq_chz <= 16'h17D5;
        quiet(2, 60);
        @(posedge clock);
        sw.at_rated_speed <= 1'b1;
        wt(2, 49 * T, 51 * T + 6);
        @(posedge clock);
        mw.gen_freq_chz <= 16'h17D4;
        quiet(2, 20);
        @(posedge clock);
        mw.gen_freq_chz <= 16'h170B;
        wt(2, 0, 6);
        @(posedge clock);
        sw.at_rated_speed <= 1'b0;
        quiet(2, 10);
        @(posedge clock);
        mw <= nom;
        sw.speed_bias_at_limit <= 1'b1;
        wt(3, 99 * T, 101 * T + 6);
        @(posedge clock);
        sw.speed_bias_at_limit <= 1'b0;
        sw.volt_bias_at_var <= 1'b1;
        repeat (50 * T) @(negedge clock);
        @(posedge clock);
        sw.volt_bias_at_var <= 1'b0;
        @(posedge clock);
        sw.volt_bias_at_max_v <= 1'b1;
        wt(4, 99 * T, 101 * T + 6);
        @(posedge clock);
        sw.volt_bias_at_max_v <= 1'b0;
        sw.volt_bias_at_min_v <= 1'b1;
        wt(4, 0, 5);
        @(posedge clock);
        sw.volt_bias_at_min_v <= 1'b0;
        mw.phase_b_v <= 16'h0259;
        wt(7, 2 * T, 4 * T + 6);
        quiet(8, 10);
        set_act(8, 3'h2);
        wt(8, 0, 3 * T + 6);
        @(posedge clock);
        mw.phase_b_v <= 16'h0258;
        quiet(7, 10);
        set_act(9, 3'h4);
        @(posedge clock);
        mw <= nom;
        mw.phase_c_v <= 16'h012B;
        quiet(10, 60);
        quiet(9, 5);
        @(posedge clock);
        sw.breaker_closed <= 1'b1;
        wt(9, T, 3 * T + 6);
        wt(10, 0, 2 * T + 6);
        apb(1'b1, `GAS_OFF_CTRL, 32'h1);
        quiet(10, 10);
        @(posedge clock);
        mw.phase_a_v <= 16'h012B;
        wt(10, 2 * T, 4 * T + 6);
        // Clock enable low freezes the trip although the fault has gone
        @(posedge clock);
        ce <= 1'b0;
        mw.phase_a_v <= nom.phase_a_v;
        repeat (20) @(negedge clock);
        chk(32'(trip[10]), 32'h1);
        @(posedge clock);
        ce <= 1'b1;
        quiet(10, 5);
        stop_test();
    end
endmodule
